/* asram_pkg.sv */
// ************************************************************
// Host controller constants for the 128K x 8 async SRAM
// ************************************************************
package asram_pkg;

   // Geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;

   // Clock rate
   localparam int CLK_PERIOD_PS = 8000;

   // Pin timing in ps, slow speed grade
   localparam int T_CYCLE_PS      = 20000;
   localparam int T_WRITE_PULSE_PS = 15000;
   localparam int T_SETUP_ADDR_PS = 0;
   localparam int T_DATA_SETUP_PS = 10000;
   localparam int T_FLOAT_PS      = 8000;
   localparam int T_ACCESS_PS     = 20000;

   // Least times round up to whole cycles, never below one
   function automatic int cycles_min(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int WR_PULSE_CYC = cycles_min(T_WRITE_PULSE_PS);
   localparam int WR_DSU_CYC   = cycles_min(T_FLOAT_PS + T_DATA_SETUP_PS);
   localparam int RD_ACC_CYC   = cycles_min(T_ACCESS_PS) + 1;
   localparam int TURN_CYC     = cycles_min(T_FLOAT_PS);
   localparam int CNT_W        = 4;

   // Pin bundle driven toward the device
   typedef struct packed {
      logic              select_low_active_n;
      logic              select_high_active;
      logic              out_enable_n;
      logic              write_strobe_n;
      logic [ADDR_W-1:0] address_lines;
   } asram_pins_t;

   localparam asram_pins_t PINS_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, {ADDR_W{1'b0}}};

endpackage

/* asram_host.sv */
// Behaviour
// RQ1: Device holds 131072 bytes, addressed by 17 address lines.
// RQ2: Write by low select low, high select high, strobe low.
// RQ3: Read by low select and output enable low, strobe high.
// RQ4: Device floats data lines when deselected, disabled or writing.
// RQ5: Deselect puts device in standby, ignoring enable and strobe.
// RQ6: Write interval is the overlap of both selects and strobe.
// RQ7: Write starts when all three hold, ends when one leaves.
// RQ8: Host times data setup and hold to the write-ending edge.
// RQ9: Deselect with strobe rise keeps device data lines floating.
// RQ10: Host never drives data lines while the device drives them.
// RQ11: Strobe-ended write with enable low lasts float delay plus setup.
// RQ12: Read address valid no later than selects become active.
// RQ13: Address stays stable for the whole write interval.
`timescale 1ns/1ps
module asram_host
(
   // Clock and reset
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_n,
   input  wire logic                         i_ce,
   // User request port
   input  wire logic                         i_req,
   input  wire logic                         i_we,
   input  wire logic [asram_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [asram_pkg::DATA_W-1:0] i_wdata,
   output logic                              o_busy,
   output logic                              o_done,
   output logic [asram_pkg::DATA_W-1:0]      o_rdata,
   // Device pins
   output logic                              o_select_low_active_n,
   output logic                              o_select_high_active,
   output logic                              o_out_enable_n,
   output logic                              o_write_strobe_n,
   output logic [asram_pkg::ADDR_W-1:0]      o_address_lines,
   input  wire logic [asram_pkg::DATA_W-1:0] i_data_lines,
   output logic [asram_pkg::DATA_W-1:0]      o_data_lines,
   output logic                              o_data_lines_oe
);

   // ************************************************************
   // Types and state
   // ************************************************************
   typedef enum logic [2:0] {S_IDLE, S_WSET, S_WPULSE, S_WEND, S_RACC, S_TURN} asram_state_t;

   asram_state_t                       state;
   asram_state_t                       next_state;
   asram_pkg::asram_pins_t             pins;
   asram_pkg::asram_pins_t             next_pins;
   logic [asram_pkg::CNT_W-1:0]        cnt;
   logic [asram_pkg::CNT_W-1:0]        next_cnt;
   logic [asram_pkg::DATA_W-1:0]       wdata;
   logic                               oe;
   logic                               next_oe;
   logic                               busy;
   logic                               next_busy;
   logic                               done;
   logic                               next_done;
   logic [asram_pkg::DATA_W-1:0]       rdata;
   logic [asram_pkg::DATA_W-1:0]       rd_sync1;
   logic [asram_pkg::DATA_W-1:0]       rd_sync2;
   logic                               cnt_zero;

   // Elaboration checks on derived counts
   // Strobe length is the larger of pulse and float-plus-setup, so both must fit
   if (asram_pkg::WR_PULSE_CYC >= (1 << asram_pkg::CNT_W) ||
       asram_pkg::WR_DSU_CYC >= (1 << asram_pkg::CNT_W) ||
       asram_pkg::TURN_CYC >= (1 << asram_pkg::CNT_W) ||
       asram_pkg::RD_ACC_CYC + 2 >= (1 << asram_pkg::CNT_W))
   begin : g_chk
      $error("Cycle counts do not fit the counter");
   end

   // ************************************************************
   // Decode
   // ************************************************************
   assign cnt_zero = (cnt == '0);

   // Write pulse length covers strobe pulse and float plus setup
   localparam int WR_LEN = (asram_pkg::WR_PULSE_CYC > asram_pkg::WR_DSU_CYC) ?
                           asram_pkg::WR_PULSE_CYC : asram_pkg::WR_DSU_CYC;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb
   begin
      next_state = state;
      next_pins  = pins;
      next_cnt   = cnt_zero ? cnt : cnt - 1'b1;
      next_oe    = oe;
      next_busy  = busy;
      next_done  = 1'b0;
      case (state)
         S_IDLE:
         begin
            if (i_req)
            begin
               next_busy = 1'b1;
               // RQ12 address no later than the selects
               next_pins.address_lines = i_addr;
               if (i_we)
               begin
                  // RQ10 drive only with device outputs off
                  next_oe                     = 1'b1;
                  next_pins.out_enable_n      = 1'b1;
                  next_state                  = S_WSET;
               end
               else
               begin
                  // RQ3 read select with strobe high
                  next_pins.select_low_active_n = 1'b0;
                  next_pins.select_high_active  = 1'b1;
                  next_pins.out_enable_n        = 1'b0;
                  next_cnt                      = asram_pkg::CNT_W'(asram_pkg::RD_ACC_CYC);
                  next_state                    = S_RACC;
               end
            end
         end
         S_WSET:
         begin
            // RQ2 open write overlap
            next_pins.select_low_active_n = 1'b0;
            next_pins.select_high_active  = 1'b1;
            next_pins.write_strobe_n      = 1'b0;
            next_cnt                      = asram_pkg::CNT_W'(WR_LEN - 1);
            next_state                    = S_WPULSE;
         end
         S_WPULSE:
         begin
            // RQ11 pulse lasts float delay plus setup
            if (cnt_zero)
            begin
               // RQ8 strobe rise ends write, data held
               next_pins.write_strobe_n = 1'b1;
               next_state               = S_WEND;
            end
         end
         S_WEND:
         begin
            // RQ13 address kept until after strobe rise
            next_pins                     = asram_pkg::PINS_IDLE;
            next_pins.address_lines       = pins.address_lines;
            next_oe                       = 1'b0;
            next_busy                     = 1'b0;
            next_done                     = 1'b1;
            next_state                    = S_IDLE;
         end
         S_RACC:
         begin
            if (cnt_zero)
            begin
               // RQ5 deselect to standby after sample
               next_pins               = asram_pkg::PINS_IDLE;
               next_pins.address_lines = pins.address_lines;
               next_cnt                = asram_pkg::CNT_W'(asram_pkg::TURN_CYC);
               next_state              = S_TURN;
            end
         end
         S_TURN:
         begin
            // RQ10 wait for device to float
            if (cnt_zero)
            begin
               next_busy  = 1'b0;
               next_done  = 1'b1;
               next_state = S_IDLE;
            end
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
   end

   // ************************************************************
   // State registers
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= S_IDLE;
         pins  <= asram_pkg::PINS_IDLE;
         cnt   <= '0;
         oe    <= 1'b0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end
      else if (i_ce)
      begin
         state <= next_state;
         pins  <= next_pins;
         cnt   <= next_cnt;
         oe    <= next_oe;
         busy  <= next_busy;
         done  <= next_done;
      end
   end

   // Write data latched with the request, held through the write
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         wdata <= '0;
      else if (i_ce && state == S_IDLE && i_req && i_we)
         wdata <= i_wdata;
   end

   // ************************************************************
   // Read data path
   // ************************************************************
   // Pin data crosses in through two flops before use
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rd_sync1 <= '0;
         rd_sync2 <= '0;
         rdata    <= '0;
      end
      else if (i_ce)
      begin
         rd_sync1 <= i_data_lines;
         rd_sync2 <= rd_sync1;
         // Sample taken as the read closes
         if (state == S_RACC && cnt_zero)
            rdata <= rd_sync2;
      end
   end

   // ************************************************************
   // Outputs straight from flops
   // ************************************************************
   assign o_select_low_active_n = pins.select_low_active_n;
   assign o_select_high_active  = pins.select_high_active;
   assign o_out_enable_n        = pins.out_enable_n;
   assign o_write_strobe_n      = pins.write_strobe_n;
   assign o_address_lines       = pins.address_lines;
   assign o_data_lines          = wdata;
   assign o_data_lines_oe       = oe;
   assign o_busy                = busy;
   assign o_done                = done;
   assign o_rdata               = rdata;

endmodule

/* asram_dev_model.sv */
`timescale 1ns/1ps
module asram_dev_model
#(
   parameter int ACC_NS = asram_pkg::T_ACCESS_PS / 1000
)
(
   // Pins from the host
   input  wire logic                         i_select_low_active_n,
   input  wire logic                         i_select_high_active,
   input  wire logic                         i_out_enable_n,
   input  wire logic                         i_write_strobe_n,
   input  wire logic [asram_pkg::ADDR_W-1:0] i_address_lines,
   input  wire logic [asram_pkg::DATA_W-1:0] i_data_lines,
   // Pins toward the host
   output logic      [asram_pkg::DATA_W-1:0] o_data_lines,
   output logic                              o_drive
);
   logic [asram_pkg::DATA_W-1:0] mem [0:(1<<asram_pkg::ADDR_W)-1];
   wire                          selected;
   wire                          wr_act;
   wire [asram_pkg::DATA_W-1:0]  rd_now;
   wire [asram_pkg::DATA_W-1:0]  rd_late;
   assign selected = !i_select_low_active_n && i_select_high_active;
   // write only in the three-way overlap
   assign wr_act = selected && !i_write_strobe_n;
   // drive only for a selected, enabled read
   assign o_drive = selected && !i_out_enable_n && i_write_strobe_n;
   // Slow answer: stale data until the access time has run
   assign rd_now = mem[i_address_lines];
   assign #(ACC_NS) rd_late = rd_now;
   assign o_data_lines = rd_late;
   // byte taken at the write-ending edge
   always @(negedge wr_act)
      mem[i_address_lines] = i_data_lines;
endmodule

/* asram_host_asserts.sv */
`timescale 1ns/1ps
module asram_host_asserts
(
   // Clock, reset and request
   input wire logic                         i_clk,
   input wire logic                         i_rst_n,
   input wire logic                         i_ce,
   input wire logic                         i_req,
   input wire logic                         i_we,
   input wire logic [asram_pkg::ADDR_W-1:0] i_addr,
   // Observed outputs
   input wire logic                         o_busy,
   input wire logic                         o_done,
   input wire logic                         o_select_low_active_n,
   input wire logic                         o_select_high_active,
   input wire logic                         o_out_enable_n,
   input wire logic                         o_write_strobe_n,
   input wire logic [asram_pkg::ADDR_W-1:0] o_address_lines,
   input wire logic [asram_pkg::DATA_W-1:0] o_data_lines,
   input wire logic                         o_data_lines_oe
);
   // Request taken at this edge
   wire acc;
   assign acc = i_ce && i_req && !o_busy;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   AST_WR_DONE:  // write answer time
      assert property (acc && i_we |-> ##6 o_done) else $error("write done late or early");
   AST_RD_DONE:  // read answer time
      assert property (acc && !i_we |-> ##8 o_done) else $error("read done late or early");
   AST_WR_STROBE:  // three-cycle overlap window
      assert property (acc && i_we |-> ##2 (!o_write_strobe_n && !o_select_low_active_n
         && o_select_high_active)[*3] ##1 o_write_strobe_n) else $error("write window wrong");
   AST_WR_END_DATA:  // data held past write end
      assert property ($rose(o_write_strobe_n) |-> o_data_lines_oe && $stable(o_data_lines))
         else $error("data dropped at write end");
   AST_NO_FIGHT:  // no drive with outputs enabled
      assert property (o_data_lines_oe |-> o_out_enable_n) else $error("data bus contention");
   AST_WR_OE_HIGH:  // strobe write with outputs off
      assert property (!o_write_strobe_n |-> o_out_enable_n && o_data_lines_oe)
         else $error("strobe low without data or with outputs on");
   AST_WR_ADDR_HOLD:  // address steady in write
      assert property (!o_write_strobe_n && !$fell(o_write_strobe_n) |-> $stable(o_address_lines)
         && $stable(o_data_lines)) else $error("address moved in write");
   AST_RD_ADDR:  // address with first select
      assert property (acc |=> o_address_lines == $past(i_addr)) else $error("address not set");
   AST_IDLE_PINS:  // no write when idle
      assert property (!o_busy |-> o_select_low_active_n && !o_select_high_active
         && o_write_strobe_n && !o_data_lines_oe) else $error("pins active while idle");
   COV_WRITE: cover property (acc && i_we);
   COV_READ: cover property (acc && !i_we);
   COV_B2B: cover property (o_done && acc);
endmodule
bind asram_host asram_host_asserts u_chk (.*);

/* tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;
   // ************************************************************
   // Wiring
   // ************************************************************
   localparam int WR_LAT = 6;
   localparam int RD_LAT = 8;
   localparam int LIMIT  = 3000;
   logic i_clk, i_rst_n, i_ce, i_req, i_we, host_oe, dev_drive, sel_n, sel, oe_n, wr_n;
   logic [16:0] i_addr, addr;
   logic [7:0]  i_wdata, o_rdata, host_d, dev_d, bus;
   logic [7:0]  float_pat = 8'h0F;
   logic        o_busy, o_done;
   int          bad_count = 0;
   int          checked = 0;
   int          cyc = 0;
   // Undriven bus flips every cycle so stale data cannot pass
   assign bus = host_oe ? host_d : (dev_drive ? dev_d : float_pat);
   asram_host u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req), .i_we(i_we),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata),
      .o_select_low_active_n(sel_n), .o_select_high_active(sel), .o_out_enable_n(oe_n),
      .o_write_strobe_n(wr_n), .o_address_lines(addr), .i_data_lines(bus), .o_data_lines(host_d),
      .o_data_lines_oe(host_oe));
   asram_dev_model u_dev (.i_select_low_active_n(sel_n), .i_select_high_active(sel),
      .i_out_enable_n(oe_n), .i_write_strobe_n(wr_n), .i_address_lines(addr), .i_data_lines(bus),
      .o_data_lines(dev_d), .o_drive(dev_drive));
   // Clock
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Floating pattern, contention watch, hang limit
   always @(posedge i_clk)
   begin
      float_pat <= ~float_pat;
      cyc++;
      if (i_rst_n) `CHK(host_oe & dev_drive, 1'b0)
      if (cyc == LIMIT)
      begin
         bad_count++;
         conclude();
      end
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic conclude;
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Edges from accept to the done pulse, bounded
   task automatic wait_done(output int n);
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_done !== 1'b1 && n < 40);
   endtask
   task automatic op(input logic we, input logic [16:0] a, input logic [7:0] d, output int n);
      i_req   <= 1'b1;
      i_we    <= we;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_req <= 1'b0;
      wait_done(n);
   endtask
   task automatic t_reset_pins;
      `CHK({sel_n, sel, oe_n, wr_n, host_oe}, 5'h16)
   endtask
   // Reset in mid-write: pins fall back to idle, the next read runs normally
   task automatic t_mid_reset;
      int n;
      i_req   <= 1'b1;
      i_we    <= 1'b1;
      i_addr  <= 17'h00300;
      i_wdata <= 8'h77;
      @(posedge i_clk);
      i_req <= 1'b0;
      repeat (2) @(posedge i_clk);
      // Strobe is low here, so reset cuts the write short
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      `CHK({sel_n, sel, oe_n, wr_n, host_oe}, 5'h16)
      `CHK({o_busy, o_done, o_rdata}, 10'h000)
      op(1'b0, 17'h00100, 8'h00, n);
      `CHK(n, RD_LAT)
      `CHK(o_rdata, 8'h3C)
   endtask
   // End and alternating-bit addresses written then read back
   task automatic t_table;
      logic [16:0] a [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
      logic [7:0]  d [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
      int          n;
      foreach (a[i])
      begin
         op(1'b1, a[i], d[i], n);
         `CHK(n, WR_LAT)
      end
      foreach (a[i])
      begin
         op(1'b0, a[i], 8'h00, n);
         `CHK(n, RD_LAT)
         `CHK(o_rdata, d[i])
      end
   endtask
   // Request held high: changes while busy wait for the done cycle
   task automatic t_back_to_back;
      int n;
      op(1'b1, 17'h00100, 8'h3C, n);
      i_req  <= 1'b1;
      i_addr <= 17'h00100;
      @(posedge i_clk);
      i_addr  <= 17'h00200;
      i_wdata <= 8'hC3;
      wait_done(n);
      i_req <= 1'b0;
      wait_done(n);
      `CHK(n, WR_LAT)
      op(1'b0, 17'h00100, 8'h00, n);
      `CHK(o_rdata, 8'h3C)
      op(1'b0, 17'h00200, 8'h00, n);
      `CHK(o_rdata, 8'hC3)
   endtask
   // Clock enable low: a pending request is not taken
   task automatic t_ce_freeze;
      i_ce  <= 1'b0;
      i_req <= 1'b1;
      repeat (5)
      begin
         @(posedge i_clk);
         `CHK({o_busy, sel_n}, 2'h1)
      end
      i_req <= 1'b0;
      i_ce  <= 1'b1;
      @(posedge i_clk);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      i_rst_n <= 1'b0;
      i_ce    <= 1'b1;
      i_req   <= 1'b0;
      i_we    <= 1'b0;
      i_addr  <= 17'h00000;
      i_wdata <= 8'h00;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      t_reset_pins();
      t_table();
      t_back_to_back();
      t_mid_reset();
      t_ce_freeze();
      conclude();
   end
endmodule
